// ### bench/mscc_host_model.sv
// mscc_host_model: terminal on the character side of the call-control block
// assumes the bench calls send and reads got; one character per call
`timescale 1ns/100ps
module mscc_host_model
   import mscc_pkg::*;
(
   input wire logic mclk,
   input wire mscc_char_s tx_char,
   output mscc_char_s rx_char
);
   logic [7:0] got[$];
   // line quiet from time zero
   initial begin
      rx_char = '{valid: 1'b0, data: 8'h00};
   end
   // one-cycle strobe; released data is inverted so it never looks held
   task automatic send(input logic [7:0] c);
      @(posedge mclk);
      rx_char <= '{valid: 1'b1, data: c};
      @(posedge mclk);
      rx_char <= '{valid: 1'b0, data: ~c};
   endtask
   // collect every character shown to the terminal
   always @(posedge mclk) begin
      if (tx_char.valid === 1'b1) begin
         got.push_back(tx_char.data);
      end
   end
endmodule // mscc_host_model

// ### bench/mscc_top_tb.sv
// mscc_top_tb: self-checking bench for the call-control block
// assumes a one-second tick shortened to 20 clocks
`timescale 1ns/100ps
module mscc_top_tb
   import mscc_pkg::*;
;
   logic mclk = 1'b0;
   logic resetn;
   mscc_bus_s bus;
   logic [7:0] reg_rdata;
   logic ring_det;
   logic carrier_det;
   logic dtr;
   mscc_char_s rx_char;
   mscc_char_s tx_char;
   logic off_hook, online, irq;
   int n_mismatch = 0;
   int checks_done = 0;
   logic [7:0] d;
   localparam logic [7:0] DFLT [8] = '{8'h00, 8'h00, 8'h2b, 8'h0d, 8'h0a, 8'h08, 8'h02, 8'h1e};
   // 200 MHz clock
   always #2.5 mclk = ~mclk;
   mscc_top #(.TICK_CYCLES(20)) dut_u (.mclk(mclk), .resetn(resetn), .bus(bus), .reg_rdata(reg_rdata),
      .ring_det(ring_det), .carrier_det(carrier_det), .dtr(dtr), .rx_char(rx_char), .tx_char(tx_char),
      .off_hook(off_hook), .online(online), .irq(irq));
   mscc_host_model host_u (.mclk(mclk), .tx_char(tx_char), .rx_char(rx_char));
   // verdict and end of run
   task automatic results();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   // register port cycles
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge mclk);
      bus <= '0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge mclk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      bus <= '0;
      #1 v = reg_rdata;
   endtask
   task automatic ring();
      @(posedge mclk);
      ring_det <= 1'b1;
      @(posedge mclk);
      ring_det <= 1'b0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // bounded wait for n characters at the terminal
   task automatic wait_tx(input int n);
      int i;
      for (i = 0; i < 400 && host_u.got.size() < n; i++) @(posedge mclk);
      #1;
      if (host_u.got.size() < n) begin
         n_mismatch++;
         $display("BAD tx count expected %0d seen %0d", n, host_u.got.size());
         results();
      end
   endtask
   // reset values, read-only and unmapped places
   task automatic t_defaults();
      for (int i = 0; i < 8; i++) begin
         rd(i[3:0], d);
         cmp("reset value", DFLT[i], d);
      end
      wr(MSCC_A_RCNT, 8'h55);
      rd(MSCC_A_RCNT, d);
      cmp("ring count ro", 8'h00, d);
      rd(4'hf, d);
      cmp("unmapped", 8'h00, d);
   endtask
   // ring counter clears after eight quiet seconds; zero disables answer
   task automatic t_ring_gap();
      ring();
      cyc(150);
      rd(MSCC_A_RCNT, d);
      cmp("ring count", 8'h01, d);
      cmp("no answer", 8'h00, {7'h00, off_hook});
      cyc(20);
      rd(MSCC_A_RCNT, d);
      cmp("ring gap clear", 8'h00, d);
   endtask
   // answer on the second ring, then connect, no line feed in short form
   task automatic t_answer();
      wr(MSCC_A_RTA, 8'h02);
      ring();
      cyc(2);
      cmp("early answer", 8'h00, {7'h00, off_hook});
      ring();
      cyc(2);
      cmp("answered", 8'h01, {7'h00, off_hook});
      @(posedge mclk);
      carrier_det <= 1'b1;
      wait_tx(2);
      cmp("connect code", MSCC_RES_CONNECT, host_u.got[0]);
      cmp("terminator", 8'h0d, host_u.got[1]);
      cyc(4);
      cmp("no lf", 8'h02, 8'(host_u.got.size()));
      cmp("online", 8'h01, {7'h00, online});
      @(posedge mclk);
      carrier_det <= 1'b0;
      cyc(3);
      cmp("hung up", 8'h00, {7'h00, off_hook});
      wr(MSCC_A_RTA, 8'h00);
      host_u.got.delete();
   endtask
   // dial, dial tone wait, carrier timeout with verbose codes
   task automatic t_dial();
      wr(MSCC_A_CW, 8'h03);
      wr(MSCC_A_CTRL, 8'h05);
      cyc(25);
      rd(MSCC_A_STATE, d);
      cmp("dial tone wait", 8'h02, d);
      cyc(30);
      rd(MSCC_A_STATE, d);
      cmp("carrier wait", 8'h04, d);
      wait_tx(3);
      cmp("no carrier code", MSCC_RES_NOCARR, host_u.got[0]);
      cmp("terminator", 8'h0d, host_u.got[1]);
      cmp("line feed", 8'h0a, host_u.got[2]);
      cmp("off hook", 8'h00, {7'h00, off_hook});
      wr(MSCC_A_CTRL, 8'h00);
      host_u.got.delete();
   endtask
   // go on-line by dialing with carrier present
   task automatic go_online(input logic [7:0] ctrl);
      carrier_det <= 1'b1;
      wr(MSCC_A_CTRL, ctrl);
      wait_tx(2);
      host_u.got.delete();
      cmp("online", 8'h01, {7'h00, online});
   endtask
   // escape off above 127, ready drop, then escape with the default char
   task automatic t_escape();
      wr(MSCC_A_ESC, 8'h80);
      go_online(8'h06);
      repeat (3) host_u.send(8'h80);
      cyc(3);
      cmp("escape off", 8'h01, {7'h00, online});
      @(posedge mclk);
      dtr <= 1'b0;
      cyc(3);
      rd(MSCC_A_STATE, d);
      cmp("ready drop", 8'h10, d);
      @(posedge mclk);
      dtr <= 1'b1;
      carrier_det <= 1'b0;
      cyc(3);
      wr(MSCC_A_ESC, 8'h2b);
      go_online(8'h04);
      repeat (3) host_u.send(8'h2b);
      cyc(3);
      rd(MSCC_A_STATE, d);
      cmp("escape", 8'h10, d);
      @(posedge mclk);
      carrier_det <= 1'b0;
      cyc(3);
      host_u.got.delete();
   endtask
   // command entry with erase, line done interrupt
   task automatic t_cmd();
      wr(MSCC_A_ERASE, 8'h7f);
      wr(MSCC_A_IMASK, 8'h08);
      host_u.send(8'h41);
      host_u.send(8'h42);
      host_u.send(8'h7f);
      host_u.send(8'h0d);
      wait_tx(4);
      cmp("echo erase", 8'h7f, host_u.got[2]);
      cmp("echo term", 8'h0d, host_u.got[3]);
      rd(MSCC_A_CLEN, d);
      cmp("line length", 8'h01, d);
      wr(MSCC_A_CIDX, 8'h00);
      cyc(1);
      rd(MSCC_A_CDATA, d);
      cmp("buffer byte", 8'h41, d);
      cmp("irq", 8'h01, {7'h00, irq});
      wr(MSCC_A_ISTAT, 8'h08);
      cyc(2);
      cmp("irq clear", 8'h00, {7'h00, irq});
   endtask
   // main sequence
   initial begin
      resetn = 1'b0;
      bus = '0;
      ring_det = 1'b0;
      carrier_det = 1'b0;
      dtr = 1'b1;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      t_defaults();
      t_ring_gap();
      t_answer();
      t_dial();
      t_escape();
      t_cmd();
      results();
   end
endmodule // mscc_top_tb

// ### design/mscc_cmd_mem.sv
// mscc_cmd_mem: command line buffer, registered read port
// assumes one write and one read per clock
`timescale 1ns/100ps
module mscc_cmd_mem #(
   parameter int DEPTH = 40,
   parameter int AW = 6
) (
   input wire logic mclk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [DEPTH];

   // write port and registered read
   always_ff @(posedge mclk) begin
      if (wr_en && (32'(wr_addr) < DEPTH)) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= (32'(rd_addr) < DEPTH) ? mem[rd_addr] : 8'h00;
   end
endmodule // mscc_cmd_mem

// ### design/mscc_sec_tick.sv
// mscc_sec_tick: one-second tick generator with restart
// assumes restart is a synchronous pulse on mclk
`timescale 1ns/100ps
module mscc_sec_tick #(
   parameter int TICK_CYCLES = 200_000_000
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic restart,
   output logic tick
);
   logic [31:0] cnt_reg;

   // prescaler restarts from zero on its triggering event
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= 32'h0;
         tick <= 1'b0;
      end else if (restart) begin
         cnt_reg <= 32'h0;
         tick <= 1'b0;
      end else if (cnt_reg == 32'(TICK_CYCLES - 1)) begin
         cnt_reg <= 32'h0;
         tick <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 32'h1;
         tick <= 1'b0;
      end
   end
endmodule // mscc_sec_tick

// ### design/mscc_top.sv
// mscc_top: modem parameter registers, ring handling, auto-answer, call timing,
// escape detection and command line entry with result code output
// assumes one clock, register port strobes of one cycle, and a terminal that
// takes one character per cycle on tx_char
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module mscc_top
   import mscc_pkg::*;
#(
   parameter int TICK_CYCLES = MSCC_TICK_CYC,
   parameter int CMD_DEPTH = MSCC_CMD_DEPTH
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire mscc_bus_s bus,
   output logic [7:0] reg_rdata,
   input wire logic ring_det,
   input wire logic carrier_det,
   input wire logic dtr,
   input wire mscc_char_s rx_char,
   output mscc_char_s tx_char,
   output logic off_hook,
   output logic online,
   output logic irq
);
   logic [7:0] rta_reg, rcnt_reg, esc_reg, term_reg, lf_reg, erase_reg, dtw_reg, cw_reg;
   logic verbose_result_select, dtr_en_reg;
   logic [MSCC_I_W-1:0] istat_reg, imask_reg, ievt;
   mscc_state_e st_reg, st_next;
   logic [7:0] call_secs, gap_secs, mem_rdata;
   logic call_tick, gap_tick, call_restart;
   logic [1:0] esc_cnt, tx_stage;
   logic [7:0] res_char;
   logic [MSCC_CMD_AW-1:0] wr_ptr, clen_reg, cidx_reg;
   logic cmd_state, rx_cmd, rx_term, rx_erase, mem_wr;
   logic esc_on, esc_hit, escape_evt, answer_now, dial_cmd, hangup_cmd;
   logic dtr_drop, carrier_lost, connect_evt, nocarr_evt;

   // raise the value to the least legal figure
   function automatic logic [7:0] clamp_min(input logic [7:0] v, input logic [7:0] lo);
      clamp_min = (v < lo) ? lo : v;
   endfunction

   // true when count plus one reaches the limit
   function automatic logic reaches(input logic [7:0] cnt, input logic [7:0] lim);
      reaches = ({1'b0, cnt} + 9'h001) >= {1'b0, lim};
   endfunction

   // one-second ticks for ring gap and call timing
   mscc_sec_tick #(.TICK_CYCLES(TICK_CYCLES)) u_gap_tick (
      .mclk(mclk),
      .resetn(resetn),
      .restart(ring_det),
      .tick(gap_tick)
   );

   mscc_sec_tick #(.TICK_CYCLES(TICK_CYCLES)) u_call_tick (
      .mclk(mclk),
      .resetn(resetn),
      .restart(call_restart),
      .tick(call_tick)
   );

   // command line storage
   mscc_cmd_mem #(.DEPTH(CMD_DEPTH), .AW(MSCC_CMD_AW)) u_cmd_mem (
      .mclk(mclk),
      .wr_en(mem_wr),
      .wr_addr(wr_ptr),
      .wr_data(rx_char.data),
      .rd_addr(cidx_reg),
      .rd_data(mem_rdata)
   );

   // event decode
   assign cmd_state = (st_reg == MSCC_ST_IDLE) || (st_reg == MSCC_ST_HELD);
   assign rx_cmd = cmd_state && rx_char.valid;
   assign rx_term = rx_cmd && (rx_char.data == term_reg);
   assign rx_erase = rx_cmd && !rx_term && (rx_char.data == erase_reg);
   assign mem_wr = rx_cmd && !rx_term && !rx_erase && (32'(wr_ptr) < CMD_DEPTH);
   assign esc_on = !esc_reg[7];
   assign esc_hit = (st_reg == MSCC_ST_ONLINE) && esc_on && rx_char.valid && (rx_char.data == esc_reg);
   assign escape_evt = esc_hit && (esc_cnt == MSCC_ESC_COUNT - 2'h1);
   assign answer_now = (st_reg == MSCC_ST_IDLE) && ring_det && (rta_reg != 8'h00)
                       && reaches(rcnt_reg, rta_reg);
   assign dial_cmd = bus.wr && (bus.addr == MSCC_A_CTRL) && bus.wdata[MSCC_C_DIAL];
   assign hangup_cmd = bus.wr && (bus.addr == MSCC_A_CTRL) && bus.wdata[MSCC_C_HANGUP];
   assign dtr_drop = !dtr && dtr_en_reg;
   assign carrier_lost = !carrier_det;
   assign connect_evt = (st_reg == MSCC_ST_CWAIT) && carrier_det;
   assign nocarr_evt = (st_reg == MSCC_ST_CWAIT) && !carrier_det && call_tick
                       && reaches(call_secs, clamp_min(cw_reg, MSCC_CW_MIN));
   assign call_restart = (st_next != st_reg);
   assign ievt = {escape_evt, rx_term, nocarr_evt, connect_evt, ring_det};

   // call state transitions
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         MSCC_ST_IDLE: begin
            if (dial_cmd) begin
               st_next = MSCC_ST_DIALTONE;
            end else if (answer_now) begin
               st_next = MSCC_ST_CWAIT;
            end
         end
         MSCC_ST_DIALTONE: begin
            if (hangup_cmd) begin
               st_next = MSCC_ST_IDLE;
            end else if (call_tick && reaches(call_secs, clamp_min(dtw_reg, MSCC_DT_MIN))) begin
               st_next = MSCC_ST_CWAIT;
            end
         end
         MSCC_ST_CWAIT: begin
            if (connect_evt) begin
               st_next = MSCC_ST_ONLINE;
            end else if (nocarr_evt || hangup_cmd) begin
               st_next = MSCC_ST_IDLE;
            end
         end
         MSCC_ST_ONLINE: begin
            if (carrier_lost) begin
               st_next = MSCC_ST_IDLE;
            end else if (dtr_drop || escape_evt) begin
               st_next = MSCC_ST_HELD;
            end
         end
         MSCC_ST_HELD: begin
            if (carrier_lost || hangup_cmd) begin
               st_next = MSCC_ST_IDLE;
            end
         end
         default: st_next = MSCC_ST_IDLE;
      endcase
   end

   // call state and line outputs
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= MSCC_ST_IDLE;
         off_hook <= 1'b0;
         online <= 1'b0;
      end else begin
         st_reg <= st_next;
         off_hook <= (st_next != MSCC_ST_IDLE);
         online <= (st_next == MSCC_ST_ONLINE);
      end
   end

   // seconds elapsed in the current call state
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         call_secs <= 8'h00;
      end else if (call_restart) begin
         call_secs <= 8'h00;
      end else if (call_tick && call_secs != 8'hff) begin
         call_secs <= call_secs + 8'h01;
      end
   end

   // ring counter and ring gap timer
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rcnt_reg <= 8'h00;
         gap_secs <= 8'h00;
      end else if (ring_det) begin
         if (rcnt_reg != 8'hff) begin
            rcnt_reg <= rcnt_reg + 8'h01;
         end
         gap_secs <= 8'h00;
      end else if (gap_tick && rcnt_reg != 8'h00) begin
         if (reaches(gap_secs, MSCC_RING_GAP_SECS)) begin
            rcnt_reg <= 8'h00;
            gap_secs <= 8'h00;
         end else begin
            gap_secs <= gap_secs + 8'h01;
         end
      end
   end

   // escape character run counter
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         esc_cnt <= 2'h0;
      end else if (st_reg != MSCC_ST_ONLINE || escape_evt) begin
         esc_cnt <= 2'h0;
      end else if (rx_char.valid) begin
         esc_cnt <= esc_hit ? esc_cnt + 2'h1 : 2'h0;
      end
   end

   // command buffer pointer and completed line length
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         clen_reg <= '0;
      end else if (rx_term) begin
         clen_reg <= wr_ptr;
         wr_ptr <= '0;
      end else if (rx_erase) begin
         if (wr_ptr != '0) begin
            wr_ptr <= wr_ptr - 1'b1;
         end
      end else if (mem_wr) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   // result code sequencer: code, terminator, then line feed when verbose
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_stage <= 2'h0;
         res_char <= 8'h00;
      end else if (connect_evt || nocarr_evt) begin
         tx_stage <= 2'h3;
         res_char <= connect_evt ? MSCC_RES_CONNECT : MSCC_RES_NOCARR;
      end else if (tx_stage == 2'h2 && !verbose_result_select) begin
         tx_stage <= 2'h0;
      end else if (tx_stage != 2'h0) begin
         tx_stage <= tx_stage - 2'h1;
      end
   end

   // character output: result codes first, else echo in command state
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_char <= '0;
      end else begin
         unique case (tx_stage)
            2'h3: tx_char <= '{valid: 1'b1, data: res_char};
            2'h2: tx_char <= '{valid: 1'b1, data: term_reg};
            2'h1: tx_char <= '{valid: 1'b1, data: lf_reg};
            2'h0: tx_char <= '{valid: rx_cmd, data: rx_char.data};
         endcase
      end
   end

   // software-written parameters and control
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rta_reg <= MSCC_RST_RTA;
         esc_reg <= MSCC_RST_ESC;
         term_reg <= MSCC_RST_TERM;
         lf_reg <= MSCC_RST_LF;
         erase_reg <= MSCC_RST_ERASE;
         dtw_reg <= MSCC_RST_DTW;
         cw_reg <= MSCC_RST_CW;
         verbose_result_select <= 1'b0;
         dtr_en_reg <= 1'b0;
         imask_reg <= '0;
         cidx_reg <= '0;
      end else if (bus.wr) begin
         unique case (bus.addr)
            MSCC_A_RTA: rta_reg <= bus.wdata;
            MSCC_A_ESC: esc_reg <= bus.wdata;
            MSCC_A_TERM: term_reg <= bus.wdata;
            MSCC_A_LF: lf_reg <= bus.wdata;
            MSCC_A_ERASE: erase_reg <= bus.wdata;
            MSCC_A_DTW: dtw_reg <= bus.wdata;
            MSCC_A_CW: cw_reg <= bus.wdata;
            MSCC_A_CTRL: begin
               verbose_result_select <= bus.wdata[MSCC_C_VERBOSE];
               dtr_en_reg <= bus.wdata[MSCC_C_DTR_EN];
            end
            MSCC_A_IMASK: imask_reg <= bus.wdata[MSCC_I_W-1:0];
            MSCC_A_CIDX: cidx_reg <= bus.wdata[MSCC_CMD_AW-1:0];
            default: ;
         endcase
      end
   end

   // sticky interrupt status: a new event wins over a write-one clear
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         istat_reg <= '0;
         irq <= 1'b0;
      end else begin
         if (bus.wr && bus.addr == MSCC_A_ISTAT) begin
            istat_reg <= (istat_reg & ~bus.wdata[MSCC_I_W-1:0]) | ievt;
         end else begin
            istat_reg <= istat_reg | ievt;
         end
         irq <= |((istat_reg | ievt) & imask_reg);
      end
   end

   // read data, one cycle after the read strobe
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (bus.rd) begin
         unique case (bus.addr)
            MSCC_A_RTA: reg_rdata <= rta_reg;
            MSCC_A_RCNT: reg_rdata <= rcnt_reg;
            MSCC_A_ESC: reg_rdata <= esc_reg;
            MSCC_A_TERM: reg_rdata <= term_reg;
            MSCC_A_LF: reg_rdata <= lf_reg;
            MSCC_A_ERASE: reg_rdata <= erase_reg;
            MSCC_A_DTW: reg_rdata <= dtw_reg;
            MSCC_A_CW: reg_rdata <= cw_reg;
            MSCC_A_CTRL: reg_rdata <= {6'h00, dtr_en_reg, verbose_result_select};
            MSCC_A_STATE: reg_rdata <= {3'h0, st_reg};
            MSCC_A_ISTAT: reg_rdata <= {3'h0, istat_reg};
            MSCC_A_IMASK: reg_rdata <= {3'h0, imask_reg};
            MSCC_A_CLEN: reg_rdata <= {2'h0, clen_reg};
            MSCC_A_CIDX: reg_rdata <= {2'h0, cidx_reg};
            MSCC_A_CDATA: reg_rdata <= mem_rdata;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   sequence s_result_cr;
      tx_char.valid && tx_char.data == res_char ##1 tx_char.valid && tx_char.data == term_reg;
   endsequence

   chk_autoans_off: assert property (
      (st_reg == MSCC_ST_IDLE) && ring_det && rta_reg == 8'h00 && !dial_cmd |=> st_reg == MSCC_ST_IDLE)
      else $error("answered with auto-answer disabled");

   chk_answer_rings: assert property (
      answer_now && !dial_cmd |=> st_reg == MSCC_ST_CWAIT ##0 off_hook)
      else $error("ring count reached but no answer");

   chk_ring_incr: assert property (
      ring_det && rcnt_reg != 8'hff |=> rcnt_reg == $past(rcnt_reg) + 8'h01)
      else $error("ring counter did not step");

   chk_ring_gap: assert property (
      gap_tick && !ring_det && rcnt_reg != 8'h00 && gap_secs == 8'h07 |=> rcnt_reg == 8'h00)
      else $error("ring counter not cleared after gap");

   chk_esc_off: assert property (
      st_reg == MSCC_ST_ONLINE && esc_reg[7] && carrier_det && !dtr_drop |=> st_reg == MSCC_ST_ONLINE)
      else $error("left data state with escape disabled");

   chk_line_end: assert property (
      rx_term |=> istat_reg[MSCC_I_LINE] && wr_ptr == '0)
      else $error("terminator did not end the line");

   chk_lf_verbose: assert property (
      tx_stage == 2'h2 ##0 s_result_cr ##0 ($past(verbose_result_select) && !$past(connect_evt || nocarr_evt))
      |=> tx_char.valid && tx_char.data == lf_reg)
      else $error("line feed missing with verbose results");

   chk_lf_quiet: assert property (
      tx_stage == 2'h2 && !verbose_result_select && !connect_evt && !nocarr_evt
      |=> ##1 !(tx_char.valid && tx_char.data == lf_reg && !$past(rx_cmd)))
      else $error("line feed sent without verbose results");

   chk_erase_echo: assert property (
      rx_erase && tx_stage == 2'h0 && wr_ptr != '0 |=> tx_char.valid && tx_char.data == erase_reg
      && wr_ptr == $past(wr_ptr) - 1'b1)
      else $error("erase not echoed or buffer not shortened");

   chk_no_carrier: assert property (
      nocarr_evt |=> st_reg == MSCC_ST_IDLE && !off_hook ##1 tx_char.valid && tx_char.data == MSCC_RES_NOCARR)
      else $error("carrier timeout without hang-up report");

   chk_connect: assert property (
      connect_evt |=> online ##1 tx_char.valid && tx_char.data == MSCC_RES_CONNECT)
      else $error("carrier found but no connect");
endmodule // mscc_top

// ### shared/mscc_pkg.sv
// mscc_pkg: constants, types and register map of the modem call-control block
// assumes a single 200 MHz clock domain shared by every design file
package mscc_pkg;
   // timing
   localparam int MSCC_CLK_NS = 5;
   localparam int MSCC_SEC_NS = 1_000_000_000;
   localparam int MSCC_TICK_CYC = MSCC_SEC_NS / MSCC_CLK_NS;
   localparam logic [7:0] MSCC_RING_GAP_SECS = 8'h08;
   localparam logic [7:0] MSCC_DT_MIN = 8'h02;
   localparam logic [7:0] MSCC_CW_MIN = 8'h01;
   localparam logic [1:0] MSCC_ESC_COUNT = 2'h3;
   localparam int MSCC_CMD_DEPTH = 40;
   localparam int MSCC_CMD_AW = 6;
   // register indexes
   localparam logic [3:0] MSCC_A_RTA = 4'h0;
   localparam logic [3:0] MSCC_A_RCNT = 4'h1;
   localparam logic [3:0] MSCC_A_ESC = 4'h2;
   localparam logic [3:0] MSCC_A_TERM = 4'h3;
   localparam logic [3:0] MSCC_A_LF = 4'h4;
   localparam logic [3:0] MSCC_A_ERASE = 4'h5;
   localparam logic [3:0] MSCC_A_DTW = 4'h6;
   localparam logic [3:0] MSCC_A_CW = 4'h7;
   localparam logic [3:0] MSCC_A_CTRL = 4'h8;
   localparam logic [3:0] MSCC_A_STATE = 4'h9;
   localparam logic [3:0] MSCC_A_ISTAT = 4'ha;
   localparam logic [3:0] MSCC_A_IMASK = 4'hb;
   localparam logic [3:0] MSCC_A_CLEN = 4'hc;
   localparam logic [3:0] MSCC_A_CIDX = 4'hd;
   localparam logic [3:0] MSCC_A_CDATA = 4'he;
   // reset values
   localparam logic [7:0] MSCC_RST_RTA = 8'h00;
   localparam logic [7:0] MSCC_RST_ESC = 8'h2b;
   localparam logic [7:0] MSCC_RST_TERM = 8'h0d;
   localparam logic [7:0] MSCC_RST_LF = 8'h0a;
   localparam logic [7:0] MSCC_RST_ERASE = 8'h08;
   localparam logic [7:0] MSCC_RST_DTW = 8'h02;
   localparam logic [7:0] MSCC_RST_CW = 8'h1e;
   // control bits
   localparam int MSCC_C_VERBOSE = 0;
   localparam int MSCC_C_DTR_EN = 1;
   localparam int MSCC_C_DIAL = 2;
   localparam int MSCC_C_HANGUP = 3;
   // interrupt bits
   localparam int MSCC_I_RING = 0;
   localparam int MSCC_I_CONNECT = 1;
   localparam int MSCC_I_NOCARR = 2;
   localparam int MSCC_I_LINE = 3;
   localparam int MSCC_I_ESCAPE = 4;
   localparam int MSCC_I_W = 5;
   // result code characters
   localparam logic [7:0] MSCC_RES_CONNECT = 8'h31;
   localparam logic [7:0] MSCC_RES_NOCARR = 8'h33;
   // call states
   typedef enum logic [4:0] {
      MSCC_ST_IDLE = 5'h01,
      MSCC_ST_DIALTONE = 5'h02,
      MSCC_ST_CWAIT = 5'h04,
      MSCC_ST_ONLINE = 5'h08,
      MSCC_ST_HELD = 5'h10
   } mscc_state_e;
   // one character with its strobe
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } mscc_char_s;
   // register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } mscc_bus_s;
endpackage
